// *** verilog/urr_pkg.sv ***
// Package of constants for the asynchronous receive recovery block
// Function
// - Sample 16 per bit, 8 double speed
// - Idle falling edge starts detection, sample one
// - Start check samples 8-10 or 4-6
// - Two high check samples reject start
// - Valid start realigns bit timing each frame
// - Per-bit state count 16 or 8
// - Bits decided by three-sample majority vote
// - Recover through first stop, ignore others
// - Stop bit zero sets framing error
// - Next start detectable after last stop check sample
// - Data plus parity five to ten bits
// - Framing error stored with its frame
// - Parity check only when enabled, type selectable
// - Receiver disable aborts frame, flushes data
package urr_pkg;
  // ----------------------------------------------------------------
  // Timing and frame constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int          DIV_W         = 12;
  localparam logic [4:0]  SPB_NORMAL    = 5'h10;
  localparam logic [4:0]  SPB_DOUBLE    = 5'h08;
  localparam logic [4:0]  VOTE_FIRST_N  = 5'h08;
  localparam logic [4:0]  VOTE_FIRST_D  = 5'h04;
  localparam logic [3:0]  BITS_MIN      = 4'h5;
  localparam logic [3:0]  BITS_MAX      = 4'ha;
  localparam int          BITS_W        = 10;
  // ----------------------------------------------------------------
  // Status and mask layout
  // ----------------------------------------------------------------
  localparam int          ST_DONE       = 0;
  localparam int          ST_FERR       = 1;
  localparam int          ST_PERR       = 2;
  localparam int          ST_NOISE      = 3;
  localparam logic [3:0]  ST_RESET      = 4'h0;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  localparam logic [3:0]  CFG_BITS_RST  = 4'h8;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0]  A_CTRL        = 4'h0;
  localparam logic [3:0]  A_DIV         = 4'h4;
  localparam logic [3:0]  A_DATA        = 4'h8;
  localparam logic [3:0]  A_STAT        = 4'hc;
  localparam logic [3:0]  A_MASK        = 4'h2;
  // Control field positions
  localparam int          C_EN          = 0;
  localparam int          C_DBL         = 1;
  localparam int          C_PEN         = 2;
  localparam int          C_PODD        = 3;
  localparam int          C_BITS_LO     = 4;
  typedef enum logic [1:0] {URR_IDLE, URR_START, URR_DATA, URR_STOP} urr_state_t;
endpackage

// *** verilog/urr_tick.sv ***
// Sample tick divider for the receive recovery block
`timescale 1ns/10ps
`default_nettype none
module urr_tick (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst,
  input  wire logic                     i_en,
  input  wire logic [urr_pkg::DIV_W-1:0] i_div,
  output logic                          o_tick
);
  logic [urr_pkg::DIV_W-1:0] cnt_r;
  wire                       wrap = (cnt_r == '0);
  // Divisor n gives a tick every n+1 clocks
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      cnt_r <= '0;
    else if (!i_en || wrap)
      cnt_r <= i_div;
    else
      cnt_r <= cnt_r - 1'b1;
  assign o_tick = i_en && wrap;
endmodule // urr_tick
`default_nettype wire

// *** verilog/urr_rx.sv ***
// Asynchronous receive recovery: start detect, majority vote, framing
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module urr_rx (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_rxd,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]                ctrl_r;
  logic [urr_pkg::DIV_W-1:0] div_r;
  logic [3:0]                stat_r;
  logic [3:0]                mask_r;
  logic [11:0]               hold_r;   // data, framing, parity err
  logic                      hold_v_r;
  logic [31:0]               rdata_r;
  wire en         = ctrl_r[urr_pkg::C_EN];
  wire dbl        = ctrl_r[urr_pkg::C_DBL];       // double_speed_select
  wire pen        = ctrl_r[urr_pkg::C_PEN];       // parity_enable_setting
  wire podd       = ctrl_r[urr_pkg::C_PODD];      // parity_type_setting
  wire [3:0] bits_raw = ctrl_r[7:4];
  wire [3:0] nbits = (bits_raw < urr_pkg::BITS_MIN) ? urr_pkg::BITS_MIN :
                     (bits_raw > urr_pkg::BITS_MAX) ? urr_pkg::BITS_MAX : bits_raw;
  // ----------------------------------------------------------------
  // Line synchroniser and tick
  // ----------------------------------------------------------------
  logic sync1_r, sync2_r, prev_r;
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= i_rxd;
      sync2_r <= sync1_r;
    end
  logic tick;
  urr_tick u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_en      (en),
    .i_div     (div_r),
    .o_tick    (tick)
  );
  // ----------------------------------------------------------------
  // Recovery state machine
  // ----------------------------------------------------------------
  urr_pkg::urr_state_t st_r;
  logic [4:0]  smp_r;      // sample number equal to state
  logic [3:0]  bit_r;
  logic [2:0]  vote_r;
  logic [9:0]  shf_r;
  wire [4:0] spb   = dbl ? urr_pkg::SPB_DOUBLE : urr_pkg::SPB_NORMAL;
  wire [4:0] vfst  = dbl ? urr_pkg::VOTE_FIRST_D : urr_pkg::VOTE_FIRST_N;
  wire [4:0] vlast = vfst + 5'h2;
  wire in_vote     = (smp_r >= vfst) && (smp_r <= vlast);
  wire [2:0] vnext = in_vote ? {vote_r[1:0], sync2_r} : vote_r;
  function automatic logic maj(input logic [2:0] v);
    maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  wire vbit      = maj(vnext);
  wire last_vote = tick && (smp_r == vlast);
  wire fall      = tick && prev_r && !sync2_r;
  // Short frames sit at the top of the shifter, so align first
  wire [9:0] dshift = shf_r >> (5'd10 - {1'b0, nbits});
  // Parity over data only; parity bit is top received bit
  wire [9:0] dmask = (10'h3ff >> (5'd10 - {1'b0, nbits})) >> pen;
  wire par_calc    = ^(dshift & dmask);
  wire par_bit     = dshift[nbits - 4'h1];
  wire perr        = pen && ((par_calc ^ par_bit) != podd);
  wire frame_done  = (st_r == urr_pkg::URR_STOP) && last_vote;
  wire start_rej   = (st_r == urr_pkg::URR_START) && last_vote && vbit;
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      st_r   <= urr_pkg::URR_IDLE;
      smp_r  <= '0;
      bit_r  <= '0;
      vote_r <= '0;
      shf_r  <= '0;
      prev_r <= 1'b1;
    end
    else if (!en)
    begin
      st_r   <= urr_pkg::URR_IDLE;
      smp_r  <= '0;
      prev_r <= 1'b1;
    end
    else if (tick)
    begin
      prev_r <= sync2_r;
      vote_r <= vnext;
      case (st_r)
        urr_pkg::URR_IDLE:
          if (fall)
          begin
            st_r  <= urr_pkg::URR_START;
            smp_r <= 5'h2;
          end
        urr_pkg::URR_START:
          if (last_vote)
          begin
            if (vbit)
            begin
              st_r  <= urr_pkg::URR_IDLE;
              smp_r <= '0;
            end
            else
            begin
              st_r  <= urr_pkg::URR_DATA;
              // Tail of the start bit wraps this to zero
              bit_r <= '1;
              smp_r <= smp_r + 5'h1;
            end
          end
          else
            smp_r <= smp_r + 5'h1;
        urr_pkg::URR_DATA:
        begin
          if (last_vote)
            shf_r <= {vbit, shf_r[9:1]};
          if (smp_r == spb)
          begin
            smp_r <= 5'h1;
            if (bit_r == nbits - 4'h1)
              st_r <= urr_pkg::URR_STOP;
            else
              bit_r <= bit_r + 4'h1;
          end
          else
            smp_r <= smp_r + 5'h1;
        end
        urr_pkg::URR_STOP:
          if (last_vote)
          begin
            st_r  <= urr_pkg::URR_IDLE;
            smp_r <= '0;
          end
          else
            smp_r <= smp_r + 5'h1;
        default:
          st_r <= urr_pkg::URR_IDLE;
      endcase
    end
  // ----------------------------------------------------------------
  // Register port, holding word and status
  // ----------------------------------------------------------------
  wire rd_stat = i_rd && (i_addr == urr_pkg::A_STAT);
  wire rd_data = i_rd && (i_addr == urr_pkg::A_DATA);
  wire [3:0] ev = {start_rej, frame_done && perr, frame_done && !vbit, frame_done};
  logic [31:0] rsel;
  always_comb
  begin
    if (i_addr == urr_pkg::A_CTRL)
      rsel = {24'h0, ctrl_r};
    else if (i_addr == urr_pkg::A_DIV)
      rsel = {20'h0, div_r};
    else if (i_addr == urr_pkg::A_DATA)
      rsel = {19'h0, hold_v_r, hold_r};
    else if (i_addr == urr_pkg::A_STAT)
      rsel = {28'h0, stat_r};
    else if (i_addr == urr_pkg::A_MASK)
      rsel = {28'h0, mask_r};
    else
      rsel = 32'h0;
  end
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      ctrl_r   <= {urr_pkg::CFG_BITS_RST, 4'h0};
      div_r    <= '0;
      mask_r   <= urr_pkg::MASK_RESET;
      stat_r   <= urr_pkg::ST_RESET;
      hold_r   <= '0;
      hold_v_r <= 1'b0;
      rdata_r  <= '0;
    end
    else
    begin
      rdata_r <= i_rd ? rsel : 32'h0;
      if (i_wr && i_addr == urr_pkg::A_CTRL)
        ctrl_r <= i_wdata[7:0];
      if (i_wr && i_addr == urr_pkg::A_DIV)
        div_r <= i_wdata[urr_pkg::DIV_W-1:0];
      if (i_wr && i_addr == urr_pkg::A_MASK)
        mask_r <= i_wdata[3:0];
      // Event set wins over read clear
      stat_r <= (rd_stat ? 4'h0 : stat_r) | ev;
      if (!en)
      begin
        hold_r   <= '0;
        hold_v_r <= 1'b0;
      end
      else if (frame_done)
      begin
        hold_r   <= {perr, !vbit, dshift};
        hold_v_r <= 1'b1;
      end
      else if (rd_data)
        hold_v_r <= 1'b0;
    end
  assign o_rdata = rdata_r;
  assign o_irq   = |(stat_r & mask_r);
endmodule // urr_rx
`default_nettype wire

// *** tb/urr_rx_asserts.sv ***
// Port checker for the receive recovery block
`timescale 1ns/10ps
`default_nettype none
module urr_rx_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_rxd,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq
);
  logic [3:0]  mask_r;
  logic [11:0] div_r;
  logic [7:0]  ctrl_r;
  logic [3:0]  dis_r;
  logic [3:0]  adq_r;
  logic        rdq_r;
  wire logic rd_st = rdq_r && adq_r == urr_pkg::A_STAT;
  wire logic rd_dt = rdq_r && adq_r == urr_pkg::A_DATA;
  wire logic rd_mk = rdq_r && adq_r == urr_pkg::A_MASK;
  wire logic rd_dv = rdq_r && adq_r == urr_pkg::A_DIV;
  wire logic rd_ct = rdq_r && adq_r == urr_pkg::A_CTRL;
  wire logic wr_at = i_wr && !i_rst;
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      {mask_r, div_r, ctrl_r, dis_r, adq_r, rdq_r} <= {16'h0, 8'h80, 9'h0};
    else
    begin
      {rdq_r, adq_r} <= {i_rd, i_addr};
      mask_r <= (wr_at && i_addr == urr_pkg::A_MASK) ? i_wdata[3:0] : mask_r;
      div_r <= (wr_at && i_addr == urr_pkg::A_DIV) ? i_wdata[11:0] : div_r;
      ctrl_r <= (wr_at && i_addr == urr_pkg::A_CTRL) ? i_wdata[7:0] : ctrl_r;
      dis_r <= ctrl_r[0] ? 4'h0 : dis_r + {3'h0, dis_r != 4'hf};
    end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Status read long after the receiver went quiet
  sequence s_quiet_rd;
    dis_r == 4'hf && i_rd && i_addr == urr_pkg::A_STAT;
  endsequence
  // ----
  // Assertions
  // ----
  chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside a read");
  chk_stat_layout: assert property (rd_st |-> o_rdata[31:4] == 28'h0)
    else $error("status upper bits set");
  chk_data_layout: assert property (rd_dt |-> o_rdata[31:13] == 19'h0)
    else $error("data upper bits set");
  chk_mask_back: assert property (rd_mk |-> o_rdata == {28'h0, mask_r})
    else $error("mask readback");
  chk_div_back: assert property (rd_dv |-> o_rdata == {20'h0, div_r})
    else $error("divisor readback");
  chk_ctrl_back: assert property (rd_ct && ctrl_r[7:4] inside {[4'h5:4'ha]}
    |-> o_rdata == {24'h0, ctrl_r}) else $error("control readback");
  chk_irq_masked: assert property (mask_r == 4'h0 |-> !o_irq)
    else $error("interrupt with empty mask");
  chk_quiet_dis: assert property (s_quiet_rd ##[1:4] s_quiet_rd |=> o_rdata[3:0] == 4'h0)
    else $error("event while disabled");
endmodule // urr_rx_asserts
bind urr_rx urr_rx_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rxd(i_rxd),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
`default_nettype wire

// *** tb/urr_tx_model.sv ***
// Remote serial transmitter driving the receive line
`timescale 1ns/10ps
`default_nettype none
module urr_tx_model (
  input  wire logic i_clk,
  output logic      o_line
);
  initial o_line = 1'b1;
  // Start low, bits lsb first, one stop, exact local rate
  task automatic send(input logic [9:0] b, input int n, input int bt, input logic st,
                      input int sl);
    o_line <= 1'b0;
    repeat (bt) @(posedge i_clk);
    for (int k = 0; k < n; k++)
    begin
      o_line <= b[k];
      repeat (bt) @(posedge i_clk);
    end
    o_line <= st;
    repeat (sl) @(posedge i_clk);
    // High stop left as is, so a following frame can start at once
    if (!st)
      o_line <= 1'b1;
  endtask
  task automatic spike(input int w);
    o_line <= 1'b0;
    repeat (w) @(posedge i_clk);
    o_line <= 1'b1;
  endtask
endmodule // urr_tx_model
`default_nettype wire

// *** tb/urr_rx_tb.sv ***
// Testbench for the receive recovery block
`timescale 1ns/10ps
`default_nettype none
module urr_rx_tb;
  typedef struct {logic [7:0] c; logic [9:0] b; logic s; logic [12:0] e;} urr_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  a = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        irq;
  wire         rxd;
  int          n_fail = 0;
  int          n_checks = 0;
  urr_row_t rows [8] = '{'{8'h81, 10'h0a5, 1'b1, 13'h10a5}, '{8'h83, 10'h05a, 1'b1, 13'h105a},
    '{8'h51, 10'h015, 1'b1, 13'h1015}, '{8'ha1, 10'h3c3, 1'b1, 13'h13c3},
    '{8'h83, 10'h03c, 1'b0, 13'h143c}, '{8'h85, 10'h081, 1'b1, 13'h1081},
    '{8'h8d, 10'h081, 1'b1, 13'h1881}, '{8'h81, 10'h0ff, 1'b0, 13'h14ff}};
  always #2.5 clk = ~clk;
  urr_tx_model tx (.i_clk(clk), .o_line(rxd));
  urr_rx dut (.i_clk_sys(clk), .i_rst(rst), .i_rxd(rxd), .i_addr(a), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_irq(irq));
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wrt(input logic [3:0] x, input logic [31:0] d);
    @(posedge clk);
    {a, wd, wr} <= {x, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] x, input logic [31:0] e);
    @(posedge clk);
    {a, rd} <= {x, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdat);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Whole run is under ten thousand cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(urr_pkg::A_CTRL, 32'h80);
    rdc(urr_pkg::A_DIV, 32'h0);
    rdc(urr_pkg::A_MASK, 32'h0);
    rdc(urr_pkg::A_STAT, 32'h0);
    rdc(urr_pkg::A_DATA, 32'h0);
    rdc(4'h6, 32'h0);
    wrt(urr_pkg::A_DIV, 32'h1);
    wrt(urr_pkg::A_MASK, 32'h1);
    foreach (rows[i])
    begin
      wrt(urr_pkg::A_CTRL, {24'h0, rows[i].c});
      tx.send(rows[i].b, rows[i].c[7:4], rows[i].c[1] ? 16 : 32, rows[i].s,
              rows[i].c[1] ? 16 : 32);
      chk("irq", 32'h1, {31'h0, irq});
      rdc(urr_pkg::A_STAT, {29'h0, rows[i].e[11:10], 1'b1});
      rdc(urr_pkg::A_DATA, {19'h0, rows[i].e});
    end
    // Spike of three samples, voted out
    wrt(urr_pkg::A_MASK, 32'h8);
    tx.spike(6);
    repeat (40) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(urr_pkg::A_STAT, 32'h8);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(urr_pkg::A_DATA, 32'h04ff);
    // Short stop, next start right behind it
    wrt(urr_pkg::A_MASK, 32'h1);
    tx.send(10'h12, 8, 32, 1'b1, 24);
    tx.send(10'h34, 8, 32, 1'b1, 32);
    rdc(urr_pkg::A_STAT, 32'h1);
    rdc(urr_pkg::A_DATA, 32'h1034);
    // Disable in mid frame with unread data held
    tx.send(10'h55, 8, 32, 1'b1, 32);
    fork
      tx.send(10'h66, 8, 32, 1'b1, 32);
      begin
        repeat (100) @(posedge clk);
        wrt(urr_pkg::A_CTRL, 32'h80);
      end
    join
    repeat (20) @(posedge clk);
    rdc(urr_pkg::A_STAT, 32'h1);
    rdc(urr_pkg::A_STAT, 32'h0);
    wrt(urr_pkg::A_CTRL, 32'h81);
    rdc(urr_pkg::A_DATA, 32'h0);
    conclude();
  end
endmodule // urr_rx_tb
`default_nettype wire
